// File: hw/dcob_regs.svh
// object indices, field positions, reset values and timing counts of the drive config bank
`ifndef DCOB_REGS_SVH
`define DCOB_REGS_SVH

// ----------------------------------------------------------------------------
// object indices
// ----------------------------------------------------------------------------
`define DCOB_IDX_DEBUG 16'h2600
`define DCOB_IDX_CUSTOMER 16'h2701
`define DCOB_IDX_REBOOT 16'h2800
`define DCOB_IDX_SUBMODE 16'h3202
`define DCOB_IDX_FEEDBACK 16'h3203

// ----------------------------------------------------------------------------
// subindices and entry counts
// ----------------------------------------------------------------------------
`define DCOB_SUB_COUNT 8'h00
`define DCOB_SUB_REBOOT_CMD 8'h01
`define DCOB_SUB_REBOOT_DELAY 8'h02
`define DCOB_SUB_BOOT_HWCFG 8'h03
`define DCOB_DEBUG_ENTRIES 8'h40
`define DCOB_CUSTOMER_ENTRIES 8'hFE
`define DCOB_REBOOT_ENTRIES 8'h03
`define DCOB_FEEDBACK_ENTRIES 8'h03

// ----------------------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------------------
`define DCOB_REBOOT_MAGIC 32'h746F6F62
`define DCOB_HWCFG_NO_SHORT 0
`define DCOB_SM_LOOP 0
`define DCOB_SM_VRAMP 1
`define DCOB_SM_BRAKE 2
`define DCOB_SM_CURRENT_REDUCTION 3
`define DCOB_SM_ALIGN 4
`define DCOB_SM_TORQUE 5
`define DCOB_SM_BRUSHLESS_MOTOR_TYPE 6
`define DCOB_SM_SLOW 7
`define DCOB_SM_USED_MASK 32'h000000FF
`define DCOB_FB_POS 0
`define DCOB_FB_VEL 1
`define DCOB_FB_COMM 2

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define DCOB_RST_WORD 32'h00000000
`define DCOB_RST_BYTE 8'h00
`define DCOB_MS_IN_NS 1000000
`define DCOB_CLK_PERIOD_NS 4
`define DCOB_CYCLES_PER_MS (`DCOB_MS_IN_NS / `DCOB_CLK_PERIOD_NS)

`endif

// File: hw/dcob_pkg.sv
// types shared by the drive config object bank
package dcob_pkg;

    // commutation loop progress after power-up or loop change
    typedef enum logic [1:0] {
        LOOP_OPEN = 2'b00,
        LOOP_ALIGNING = 2'b01,
        LOOP_CLOSED = 2'b11,
        LOOP_WAIT_INDEX = 2'b10
    } dcob_loop_t;

    // sensor number 1..3, 1 is the sensorless feedback
    typedef logic [1:0] dcob_sensor_t;

endpackage : dcob_pkg

// File: hw/dcob_reboot_if.sv
// carrier between the object bank and its reboot delay timer
interface dcob_reboot_if;
    logic start;
    logic [31:0] delayMs;
    logic busy;
    logic fire;

    modport ctrl (output start, output delayMs, input busy, input fire);
    modport timer (input start, input delayMs, output busy, output fire);
endinterface : dcob_reboot_if

// File: hw/dcob_reboot_timer.sv
// millisecond delay timer that releases a commanded firmware restart
`include "dcob_regs.svh"

module dcob_reboot_timer #(
    parameter int CYCLES_PER_MS = `DCOB_CYCLES_PER_MS
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // control side
    dcob_reboot_if.timer rb
);

    localparam int TW = $clog2(CYCLES_PER_MS + 1);

    logic [TW-1:0] tick;
    logic [31:0] msLeft;
    logic busy;
    logic fire;

    assign rb.busy = busy;
    assign rb.fire = fire;

    // a new start restarts the wait with the fresh delay
    always_ff @(posedge clock) begin
        if (srst) begin
            busy <= 1'b0;
            fire <= 1'b0;
            msLeft <= `DCOB_RST_WORD;
            tick <= '0;
        end else begin
            fire <= 1'b0;
            if (rb.start) begin
                busy <= 1'b1;
                msLeft <= rb.delayMs;
                tick <= TW'(CYCLES_PER_MS - 1);
            end else if (busy) begin
                if (msLeft == 32'h00000000) begin
                    busy <= 1'b0;
                    fire <= 1'b1;
                end else if (tick == '0) begin
                    tick <= TW'(CYCLES_PER_MS - 1);
                    msLeft <= msLeft - 32'h00000001;
                end else begin
                    tick <= tick - TW'(1);
                end
            end
        end
    end

endmodule : dcob_reboot_timer

// File: hw/dcob_object_bank.sv
// drive configuration and service object bank reached by object index and subindex
//
// Operation
// - only the magic word 746F6F62 written to the reboot command restarts firmware
// - restart is postponed by the reboot delay entry, in milliseconds
// - boot config bit 0 set disables winding short in bootloader, clear enables
// - submode bit 0 picks open loop at 0, closed loop at 1
// - loop selection cannot change while operation is enabled
// - velocity ramp sim field emulates speed modes with S-ramp position steps
// - brake field enables automatic holding brake control
// - current reduction field reduces current in open loop only
// - auto align with closed loop aligns in open loop, then closes without index
// - without auto align stay in open loop until encoder index is seen
// - an encoder without index pulse forces auto alignment
// - torque field gives pure torque control only in the two torque modes
// - motor type field selects a brushless DC motor
// - slow speed field enables slow speed; master sets it after closed loop
// - feedback selection written while enabled applies at next enable entry
// - debug object offers 64 read-only bytes filled by the user program
// - customer storage offers 254 read/write words, saved as customer data
// - feedback entries: bit 0 position, bit 1 velocity, bit 2 commutation
// - sensor search starts at sensor 2 ascending, first set bit wins
`include "dcob_regs.svh"

module dcob_object_bank #(
    parameter int CYCLES_PER_MS = `DCOB_CYCLES_PER_MS,
    parameter int DEBUG_DEPTH = 64,
    parameter int CUSTOMER_DEPTH = 254
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // object access from the fieldbus stack
    input wire logic odReq,
    input wire logic odWrite,
    input wire logic [15:0] odIndex,
    input wire logic [7:0] odSub,
    input wire logic [31:0] odWdata,
    output logic odAck,
    output logic odErr,
    output logic [31:0] odRdata,
    // user program debug text
    input wire logic debugPrintWrite,
    input wire logic [5:0] debugPrintAddr,
    input wire logic [7:0] debugPrintData,
    // drive status
    input wire logic opEnabled,
    input wire logic torqueModeActive,
    input wire logic encoderHasIndex,
    input wire logic encoderIndexSeen,
    input wire logic alignDone,
    // drive controls
    output logic rebootRequest,
    output logic bootWindingShort,
    output logic loopSelect,
    output logic commutationClosed,
    output logic alignRunning,
    output logic velocityRampSim,
    output logic brakeAuto,
    output logic currentReduction,
    output logic pureTorque,
    output logic brushlessMotorType,
    output logic slowSpeed,
    // sensor assignment
    output dcob_pkg::dcob_sensor_t positionSensor,
    output dcob_pkg::dcob_sensor_t velocitySensor,
    output dcob_pkg::dcob_sensor_t commutationSensor
);

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    logic [7:0] debugCount;
    logic [7:0] debugText [DEBUG_DEPTH];
    logic [31:0] customer [CUSTOMER_DEPTH];
    logic [31:0] rebootCmd;
    logic [31:0] rebootDelay;
    logic [31:0] bootHwCfg;
    logic [31:0] submode;
    logic [7:0] fbShadow [3];
    logic [7:0] fbActive [3];
    logic [31:0] next_rdata;
    logic next_err;
    dcob_pkg::dcob_loop_t loopState;

    dcob_reboot_if rb ();

    function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub);
        hit = odReq && odWrite && (odIndex == idx) && (odSub == sub);
    endfunction : hit

    // first sensor from 2 upward with the bit set, else the sensorless one
    function automatic dcob_pkg::dcob_sensor_t pick(input int bitPos);
        if (fbActive[1][bitPos]) begin
            pick = 2'd2;
        end else if (fbActive[2][bitPos]) begin
            pick = 2'd3;
        end else begin
            pick = 2'd1;
        end
    endfunction : pick

    wire logic customerHit = odReq && odWrite && (odIndex == `DCOB_IDX_CUSTOMER)
        && (odSub != 8'h00) && (odSub <= `DCOB_CUSTOMER_ENTRIES);
    wire logic fbHit = odReq && odWrite && (odIndex == `DCOB_IDX_FEEDBACK)
        && (odSub != 8'h00) && (odSub <= `DCOB_FEEDBACK_ENTRIES);

    // ------------------------------------------------------------------------
    // debug text and customer storage
    // ------------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            debugCount <= `DCOB_RST_BYTE;
            for (int i = 0; i < DEBUG_DEPTH; i++) begin
                debugText[i] <= `DCOB_RST_BYTE;
            end
        end else begin
            if (debugPrintWrite) begin
                debugText[debugPrintAddr] <= debugPrintData;
            end
            if (hit(`DCOB_IDX_DEBUG, `DCOB_SUB_COUNT)) begin
                debugCount <= odWdata[7:0];
            end
        end
    end

    // contents survive reset; persistence is the save service's job
    always_ff @(posedge clock) begin
        if (customerHit) begin
            customer[odSub - 8'h01] <= odWdata;
        end
    end

    // ------------------------------------------------------------------------
    // reboot and boot settings
    // ------------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            rebootCmd <= `DCOB_RST_WORD;
            rebootDelay <= `DCOB_RST_WORD;
            bootHwCfg <= `DCOB_RST_WORD;
        end else begin
            if (hit(`DCOB_IDX_REBOOT, `DCOB_SUB_REBOOT_CMD)) begin
                rebootCmd <= odWdata;
            end
            if (hit(`DCOB_IDX_REBOOT, `DCOB_SUB_REBOOT_DELAY)) begin
                rebootDelay <= odWdata;
            end
            if (hit(`DCOB_IDX_REBOOT, `DCOB_SUB_BOOT_HWCFG)) begin
                bootHwCfg <= odWdata;
            end
        end
    end

    // the delay in force is the one stored before the command arrives
    assign rb.start = hit(`DCOB_IDX_REBOOT, `DCOB_SUB_REBOOT_CMD)
        && (odWdata == `DCOB_REBOOT_MAGIC);
    assign rb.delayMs = rebootDelay;

    dcob_reboot_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .clock(clock),
        .srst(srst),
        .rb(rb.timer)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            rebootRequest <= 1'b0;
            bootWindingShort <= 1'b1;
        end else begin
            rebootRequest <= rb.fire;
            bootWindingShort <= ~bootHwCfg[`DCOB_HWCFG_NO_SHORT];
        end
    end

    // ------------------------------------------------------------------------
    // submode select
    // ------------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            submode <= `DCOB_RST_WORD;
        end else if (hit(`DCOB_IDX_SUBMODE, `DCOB_SUB_COUNT)) begin
            submode <= odWdata & `DCOB_SM_USED_MASK;
            if (opEnabled) begin
                submode[`DCOB_SM_LOOP] <= submode[`DCOB_SM_LOOP];
            end
        end
    end

    // ------------------------------------------------------------------------
    // commutation loop sequencing
    // ------------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            loopState <= dcob_pkg::LOOP_OPEN;
        end else if (!submode[`DCOB_SM_LOOP]) begin
            loopState <= dcob_pkg::LOOP_OPEN;
        end else begin
            case (loopState)
                dcob_pkg::LOOP_OPEN: begin
                    if (submode[`DCOB_SM_ALIGN] || !encoderHasIndex) begin
                        loopState <= dcob_pkg::LOOP_ALIGNING;
                    end else begin
                        loopState <= dcob_pkg::LOOP_WAIT_INDEX;
                    end
                end
                dcob_pkg::LOOP_ALIGNING: begin
                    if (alignDone) begin
                        loopState <= dcob_pkg::LOOP_CLOSED;
                    end
                end
                dcob_pkg::LOOP_WAIT_INDEX: begin
                    if (encoderIndexSeen) begin
                        loopState <= dcob_pkg::LOOP_CLOSED;
                    end
                end
                dcob_pkg::LOOP_CLOSED: begin
                    loopState <= dcob_pkg::LOOP_CLOSED;
                end
                default: begin
                    loopState <= dcob_pkg::LOOP_OPEN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            loopSelect <= 1'b0;
            commutationClosed <= 1'b0;
            alignRunning <= 1'b0;
            velocityRampSim <= 1'b0;
            brakeAuto <= 1'b0;
            currentReduction <= 1'b0;
            pureTorque <= 1'b0;
            brushlessMotorType <= 1'b0;
            slowSpeed <= 1'b0;
        end else begin
            loopSelect <= submode[`DCOB_SM_LOOP];
            commutationClosed <= (loopState == dcob_pkg::LOOP_CLOSED);
            alignRunning <= (loopState == dcob_pkg::LOOP_ALIGNING);
            velocityRampSim <= submode[`DCOB_SM_VRAMP];
            brakeAuto <= submode[`DCOB_SM_BRAKE];
            currentReduction <= submode[`DCOB_SM_CURRENT_REDUCTION]
                && (loopState != dcob_pkg::LOOP_CLOSED);
            pureTorque <= submode[`DCOB_SM_TORQUE] && torqueModeActive;
            brushlessMotorType <= submode[`DCOB_SM_BRUSHLESS_MOTOR_TYPE];
            // a slow request before the loop closes is held off, not lost
            slowSpeed <= submode[`DCOB_SM_SLOW]
                && (loopState == dcob_pkg::LOOP_CLOSED);
        end
    end

    // ------------------------------------------------------------------------
    // feedback selection with buffering across operation enabled
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_fb
            always_ff @(posedge clock) begin
                if (srst) begin
                    fbShadow[g] <= `DCOB_RST_BYTE;
                    fbActive[g] <= `DCOB_RST_BYTE;
                end else begin
                    // a write while disabled lands in the active copy too
                    if (!opEnabled) begin
                        fbActive[g] <= fbShadow[g];
                    end
                    if (fbHit && (odSub == 8'(g + 1))) begin
                        fbShadow[g] <= odWdata[7:0];
                        fbActive[g] <= opEnabled ? fbActive[g] : odWdata[7:0];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (srst) begin
            positionSensor <= 2'd1;
            velocitySensor <= 2'd1;
            commutationSensor <= 2'd1;
        end else begin
            positionSensor <= pick(`DCOB_FB_POS);
            velocitySensor <= pick(`DCOB_FB_VEL);
            commutationSensor <= pick(`DCOB_FB_COMM);
        end
    end

    // ------------------------------------------------------------------------
    // object read and error decode
    // ------------------------------------------------------------------------
    always_comb begin
        next_rdata = `DCOB_RST_WORD;
        next_err = 1'b0;
        case (odIndex)
            `DCOB_IDX_DEBUG: begin
                if (odSub == `DCOB_SUB_COUNT) begin
                    next_rdata = {24'h000000, debugCount};
                end else if (odSub <= `DCOB_DEBUG_ENTRIES) begin
                    next_rdata = {24'h000000, debugText[6'(odSub - 8'h01)]};
                    next_err = odWrite;
                end else begin
                    next_err = 1'b1;
                end
            end
            `DCOB_IDX_CUSTOMER: begin
                if (odSub == `DCOB_SUB_COUNT) begin
                    next_rdata = {24'h000000, `DCOB_CUSTOMER_ENTRIES};
                    next_err = odWrite;
                end else if (odSub <= `DCOB_CUSTOMER_ENTRIES) begin
                    next_rdata = customer[odSub - 8'h01];
                end else begin
                    next_err = 1'b1;
                end
            end
            `DCOB_IDX_REBOOT: begin
                case (odSub)
                    `DCOB_SUB_COUNT: begin
                        next_rdata = {24'h000000, `DCOB_REBOOT_ENTRIES};
                        next_err = odWrite;
                    end
                    `DCOB_SUB_REBOOT_CMD: next_rdata = rebootCmd;
                    `DCOB_SUB_REBOOT_DELAY: next_rdata = rebootDelay;
                    `DCOB_SUB_BOOT_HWCFG: next_rdata = bootHwCfg;
                    default: next_err = 1'b1;
                endcase
            end
            `DCOB_IDX_SUBMODE: begin
                next_rdata = submode;
                next_err = (odSub != `DCOB_SUB_COUNT);
            end
            `DCOB_IDX_FEEDBACK: begin
                if (odSub == `DCOB_SUB_COUNT) begin
                    next_rdata = {24'h000000, `DCOB_FEEDBACK_ENTRIES};
                    next_err = odWrite;
                end else if (odSub <= `DCOB_FEEDBACK_ENTRIES) begin
                    next_rdata = {24'h000000, fbShadow[2'(odSub - 8'h01)]};
                end else begin
                    next_err = 1'b1;
                end
            end
            default: next_err = 1'b1;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            odAck <= 1'b0;
            odErr <= 1'b0;
            odRdata <= `DCOB_RST_WORD;
        end else begin
            odAck <= odReq;
            odErr <= odReq && next_err;
            if (odReq) begin
                odRdata <= next_err ? `DCOB_RST_WORD : next_rdata;
            end
        end
    end

endmodule : dcob_object_bank

// File: dv/dcob_bank_checker.sv
// port assertions for the drive config object bank
module dcob_bank_checker (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // object access
    input wire logic odReq,
    input wire logic odWrite,
    input wire logic [15:0] odIndex,
    input wire logic [7:0] odSub,
    input wire logic odAck,
    input wire logic odErr,
    input wire logic [31:0] odRdata,
    // drive status and controls
    input wire logic opEnabled,
    input wire logic torqueModeActive,
    input wire logic rebootRequest,
    input wire logic loopSelect,
    input wire logic commutationClosed,
    input wire logic currentReduction,
    input wire logic pureTorque,
    input wire logic slowSpeed
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // ----------------
    // assertions
    // ----------------
    ack_follows_req_a: assert property (odReq |=> odAck)
        else $error("no acknowledge");
    ack_has_cause_a: assert property (odAck |-> $past(odReq))
        else $error("stray acknowledge");
    err_reads_zero_a: assert property (odAck && odErr |-> odRdata == 32'h00000000)
        else $error("refused access has data");
    count_read_only_a: assert property (
        odReq && odWrite && odIndex == 16'h2701 && odSub == 8'h00 |=> odErr)
        else $error("count write accepted");
    loop_frozen_a: assert property (
        opEnabled && $past(opEnabled) && $past(opEnabled, 2) |-> $stable(loopSelect))
        else $error("loop changed while enabled");
    closed_needs_loop_a: assert property (commutationClosed |-> $past(loopSelect))
        else $error("closed loop not selected");
    reduce_open_a: assert property (currentReduction |-> !commutationClosed)
        else $error("current reduction in closed loop");
    slow_needs_closed_a: assert property (slowSpeed |-> commutationClosed)
        else $error("slow speed in open loop");
    torque_mode_a: assert property (pureTorque |-> $past(torqueModeActive))
        else $error("pure torque outside torque modes");
    reboot_pulse_a: assert property (rebootRequest |=> !rebootRequest)
        else $error("restart pulse too long");
    cover property (rebootRequest);
    cover property ($rose(commutationClosed));
    cover property (odAck && odErr);
endmodule : dcob_bank_checker

bind dcob_object_bank dcob_bank_checker u_chk (.*);

// File: dv/dcob_master_model.sv
// fieldbus master model issuing object dictionary accesses
module dcob_master_model (
    // clock
    input wire logic clock,
    // object access
    output logic odReq,
    output logic odWrite,
    output logic [15:0] odIndex,
    output logic [7:0] odSub,
    output logic [31:0] odWdata,
    input wire logic odAck,
    input wire logic odErr,
    input wire logic [31:0] odRdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {odReq, odWrite, odIndex, odSub, odWdata} = 58'h0;
    end
    // one pulse per call; the one-cycle answer is taken at once
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] d, output logic a, output logic e,
                        output logic [31:0] q);
        @(posedge clock);
        #1;
        odReq = 1'b1;
        odWrite = w;
        odIndex = idx;
        odSub = sub;
        odWdata = d;
        @(posedge clock);
        #1;
        a = odAck;
        e = odErr;
        q = odRdata;
        odReq = 1'b0;
        // released index and data lines show the inverse; odWrite and odSub keep their values
        odIndex = ~idx;
        odWdata = ~d;
    endtask : xfer
endmodule : dcob_master_model

// File: dv/drive_config_object_bank_bench.sv
// self-checking bench of the drive config object bank
module drive_config_object_bank_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CPM = 4;
    logic clock, srst, odReq, odWrite, odAck, odErr, debugPrintWrite, opEnabled;
    logic torqueModeActive, encoderHasIndex, encoderIndexSeen, alignDone, slowSpeed;
    logic rebootRequest, bootWindingShort, loopSelect, commutationClosed, alignRunning;
    logic velocityRampSim, brakeAuto, currentReduction, pureTorque, brushlessMotorType;
    logic [15:0] odIndex;
    logic [7:0] odSub, debugPrintData;
    logic [31:0] odWdata, odRdata;
    logic [5:0] debugPrintAddr;
    dcob_pkg::dcob_sensor_t positionSensor, velocitySensor, commutationSensor;
    logic [31:0] mdl [int];
    logic [15:0] seed = 16'h12EF;
    int errTotal = 0, nChecks = 0;
    int t;
    int rk [9] = '{24'h280000, 24'h280001, 24'h280002, 24'h280003, 24'h270100,
                   24'h260000, 24'h260040, 24'h320200, 24'h320300};
    dcob_object_bank #(.CYCLES_PER_MS(CPM)) DUT (.*);
    dcob_master_model mm (.*);
    // ----------------
    // helpers
    // ----------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        nChecks++;
        if (s !== x) begin
            $display("ERROR %s expected %h seen %h", n, x, s);
            errTotal++;
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    function automatic void rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    endfunction : rnd
    task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] d, input logic e);
        logic a, er;
        logic [31:0] q;
        int k = {idx, sub};
        mm.xfer(w, idx, sub, d, a, er, q);
        chk("ack", a, 1'b1);
        chk("err", er, e);
        if (!e && w) begin
            if (idx == 16'h3202 && opEnabled) d[0] = mdl[k][0];
            mdl[k] = (idx == 16'h2701 || idx == 16'h2800) ? d : d & 32'h000000FF;
        end else if (!e) chk("rdata", q, mdl[k]);
    endtask : acc
    task automatic watch(input int n, output int w);
        w = 0;
        for (int i = 1; i <= n; i++) begin
            cyc(1);
            if (rebootRequest === 1'b1 && w == 0) w = i;
        end
    endtask : watch
    task automatic conclude();
        $display("checks %0d errors %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (3000) @(posedge clock);
        errTotal++;
        conclude();
    end
    // ----------------
    // scenarios
    // ----------------
    initial begin
        {srst, debugPrintWrite, opEnabled, torqueModeActive} = 4'h9;
        {encoderHasIndex, encoderIndexSeen, alignDone} = 3'h4;
        {debugPrintAddr, debugPrintData} = 14'h0000;
        mdl = '{24'h280000: 32'h3, 24'h270100: 32'hFE, 24'h320300: 32'h3};
        foreach (rk[i]) if (!mdl.exists(rk[i])) mdl[rk[i]] = 32'h0;
        cyc(5);
        srst = 1'b0;
        chk("winding short", bootWindingShort, 1'b1);
        foreach (rk[i]) acc(1'b0, rk[i][23:8], rk[i][7:0], 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rnd();
            t = (i == 0) ? 1 : (i == 1) ? 254 : seed % 254 + 1;
            acc(1'b1, 16'h2701, t[7:0], {seed, ~seed}, 1'b0);
            acc(1'b0, 16'h2701, t[7:0], 32'h0, 1'b0);
        end
        acc(1'b1, 16'h2701, 8'h00, 32'h1, 1'b1);
        acc(1'b0, 16'h2701, 8'hFF, 32'h0, 1'b1);
        rnd();
        {debugPrintWrite, debugPrintAddr, debugPrintData} = {1'b1, 6'h3F, seed[7:0]};
        mdl[24'h260040] = {24'h0, seed[7:0]};
        cyc(1);
        debugPrintWrite = 1'b0;
        acc(1'b0, 16'h2600, 8'h40, 32'h0, 1'b0);
        acc(1'b1, 16'h2600, 8'h40, 32'h5A, 1'b1);
        acc(1'b0, 16'h2600, 8'h40, 32'h0, 1'b0);
        acc(1'b1, 16'h3202, 8'h00, 32'hFFFFFFFE, 1'b0);
        acc(1'b0, 16'h3202, 8'h00, 32'h0, 1'b0);
        cyc(2);
        chk("fields", {velocityRampSim, brakeAuto, currentReduction, pureTorque,
            brushlessMotorType, slowSpeed, loopSelect}, 7'b1111100);
        torqueModeActive = 1'b0;
        cyc(2);
        chk("pure torque", pureTorque, 1'b0);
        acc(1'b1, 16'h2800, 8'h03, 32'h1, 1'b0);
        cyc(2);
        chk("winding short", bootWindingShort, 1'b0);
        acc(1'b1, 16'h2800, 8'h02, 32'h2, 1'b0);
        acc(1'b1, 16'h2800, 8'h01, 32'h746F6F61, 1'b0);
        watch(20, t);
        chk("no restart", t, 0);
        acc(1'b1, 16'h2800, 8'h01, 32'h746F6F62, 1'b0);
        watch(20, t);
        chk("restart delay", t >= 2 * CPM && t <= 2 * CPM + 4, 1'b1);
        acc(1'b1, 16'h3202, 8'h00, 32'h1, 1'b0);
        cyc(6);
        chk("wait index", commutationClosed, 1'b0);
        encoderIndexSeen = 1'b1;
        cyc(1);
        encoderIndexSeen = 1'b0;
        cyc(3);
        chk("closed", commutationClosed, 1'b1);
        acc(1'b1, 16'h3202, 8'h00, 32'h81, 1'b0);
        cyc(3);
        chk("slow", slowSpeed, 1'b1);
        opEnabled = 1'b1;
        acc(1'b1, 16'h3202, 8'h00, 32'h0, 1'b0);
        acc(1'b0, 16'h3202, 8'h00, 32'h0, 1'b0);
        cyc(3);
        chk("loop kept", loopSelect, 1'b1);
        opEnabled = 1'b0;
        acc(1'b1, 16'h3202, 8'h00, 32'h0, 1'b0);
        cyc(3);
        chk("open", commutationClosed, 1'b0);
        for (int i = 0; i < 2; i++) begin
            encoderHasIndex = i[0];
            acc(1'b1, 16'h3202, 8'h00, i ? 32'h11 : 32'h1, 1'b0);
            cyc(3);
            chk("aligning", alignRunning, 1'b1);
            alignDone = 1'b1;
            cyc(1);
            alignDone = 1'b0;
            cyc(3);
            chk("aligned", commutationClosed, 1'b1);
            acc(1'b1, 16'h3202, 8'h00, 32'h0, 1'b0);
        end
        acc(1'b1, 16'h3203, 8'h02, 32'h2, 1'b0);
        acc(1'b1, 16'h3203, 8'h03, 32'h5, 1'b0);
        cyc(4);
        chk("sensors", {positionSensor, velocitySensor, commutationSensor}, 6'h3B);
        opEnabled = 1'b1;
        cyc(2);
        acc(1'b1, 16'h3203, 8'h02, 32'h7, 1'b0);
        acc(1'b0, 16'h3203, 8'h02, 32'h0, 1'b0);
        cyc(4);
        chk("held", {positionSensor, velocitySensor, commutationSensor}, 6'h3B);
        opEnabled = 1'b0;
        cyc(2);
        opEnabled = 1'b1;
        cyc(4);
        chk("applied", {positionSensor, velocitySensor, commutationSensor}, 6'h2A);
        conclude();
    end
endmodule : drive_config_object_bank_bench
